// ==== io_register_space_decoder.sv ====
// decoder and storage for the lower input/output register space
`timescale 1ns/1ps
module io_register_space_decoder (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // access from the processor core
    input  wire io_space_pkg::req_type   req,
    output      io_space_pkg::resp_type  resp,
    // hardware events and live inputs
    input  wire io_space_pkg::events_type events,
    input  wire io_space_pkg::inputs_type live,
    // register image and strobes toward the peripherals
    output      logic [63:0][7:0]        image,
    output      logic [1:0]              force_strobe
);
    import io_space_pkg::*;

    logic [SHORT_DEPTH-1:0][7:0] regs;
    logic [SHORT_DEPTH-1:0][7:0] next_regs;
    resp_type                    next_resp;
    logic [1:0]                  next_force;
    logic                        hit;
    logic                        ext_hit;
    logic [5:0]                  idx;
    logic                        is_io;
    logic                        is_write;
    logic                        is_bitop;
    logic [7:0]                  cur_read;
    logic [7:0]                  bit_mask;

    // map one request onto a short index; data space shifts down by the offset
    function automatic logic [6:0] decode(input req_type r);
        logic [7:0] shifted;
        shifted = r.addr - DATA_OFFSET;
        decode  = 7'h00;
        unique case (r.op)
            io_read_op, io_write_op:
                decode = {1'b1, r.addr[5:0]}; // [R05]
            set_bit_io_op, clear_bit_io_op, skip_if_bit_set_op, skip_if_bit_clear_op:
                decode = {(r.addr < BIT_LIMIT), r.addr[5:0]}; // [R01]
            load_op, memory_write_op:
                decode = {(r.addr >= DATA_OFFSET) && (r.addr <= DATA_TOP),
                          shifted[5:0]}; // [R06]
            default:
                decode = 7'h00;
        endcase
    endfunction

    // value seen by a read: stored bits plus live bits, reserved bits zero
    function automatic logic [7:0] read_value(input logic [5:0] a,
                                              input logic [SHORT_DEPTH-1:0][7:0] r,
                                              input inputs_type in);
        logic [7:0] live_bits;
        live_bits = 8'h00;
        unique case (a)
            PORT_B_PINS:   live_bits = in.port_b;
            PORT_C_PINS:   live_bits = in.port_c;
            PORT_D_PINS:   live_bits = in.port_d;
            SERIAL_STATUS: live_bits = in.serial & SERIAL_RO;
            default:       live_bits = 8'h00;
        endcase
        // strobe bits are write-only and always read zero
        if (a == TIMER0_CTL_B) begin
            live_bits = 8'h00;
        end
        read_value = ((r[a] & ~fixed_mask(a)) | (live_bits & fixed_mask(a))) & impl_mask(a); // [R10]
    endfunction

    always_comb begin
        {hit, idx} = decode(req);
        is_io      = (req.op == io_read_op) || (req.op == io_write_op);
        is_bitop   = (req.op == set_bit_io_op) || (req.op == clear_bit_io_op);
        is_write   = (req.op == io_write_op) || (req.op == memory_write_op);
        // the extended region has no port-instruction path at all
        ext_hit    = ((req.op == load_op) || (req.op == memory_write_op))
                     && (req.addr >= EXT_BASE); // [R07]
        cur_read   = read_value(idx, regs, live);
        bit_mask   = 8'h01 << req.bit_sel;
    end

    always_comb begin
        logic [7:0] keep;
        logic [7:0] wr;
        logic [7:0] clr;
        keep       = 8'h00;
        wr         = 8'h00;
        clr        = 8'h00;
        next_regs  = regs;
        next_force = 2'b00;
        if (hit && (is_write || is_bitop)) begin
            keep = impl_mask(idx) & ~fixed_mask(idx) & ~w1c_mask(idx);
            if (is_write) begin
                wr  = req.wdata;
                clr = req.wdata & w1c_mask(idx); // [R03]
                next_force = req.wdata[7:6] & FORCE_BITS[7:6] &
                             {2{idx == TIMER0_CTL_B}};
            end else begin
                // only the named bit moves; setting a flag bit writes a one to it
                wr  = (req.op == set_bit_io_op) ? (regs[idx] | bit_mask)
                                                : (regs[idx] & ~bit_mask); // [R04]
                keep = keep & bit_mask; // [R04]
                clr = (req.op == set_bit_io_op) ? (bit_mask & w1c_mask(idx)) : 8'h00; // [R03]
                next_force = (req.op == set_bit_io_op) && (idx == TIMER0_CTL_B)
                             ? FORCE_BITS[7:6] & bit_mask[7:6] : 2'b00;
            end
            next_regs[idx] = (regs[idx] & ~keep & ~clr) | (wr & keep); // [R11]
        end
        // hardware events land after the clear so a set in the same cycle wins
        next_regs[TIMER0_FLAGS]  = next_regs[TIMER0_FLAGS]  | (events.timer0 & w1c_mask(TIMER0_FLAGS));
        next_regs[TIMER1_FLAGS]  = next_regs[TIMER1_FLAGS]  | (events.timer1 & w1c_mask(TIMER1_FLAGS));
        next_regs[TIMER2_FLAGS]  = next_regs[TIMER2_FLAGS]  | (events.timer2 & w1c_mask(TIMER2_FLAGS));
        next_regs[PCHG_FLAGS]    = next_regs[PCHG_FLAGS]    | (events.pin_change & w1c_mask(PCHG_FLAGS));
        next_regs[EXT_IRQ_FLAGS] = next_regs[EXT_IRQ_FLAGS] | (events.external & w1c_mask(EXT_IRQ_FLAGS));
    end

    always_comb begin
        next_resp       = '0;
        next_resp.valid = (req.op != op_idle); // [R11]
        next_resp.hit   = hit || ext_hit;
        next_resp.ext   = ext_hit; // [R07]
        if (hit && ((req.op == io_read_op) || (req.op == load_op))) begin
            next_resp.rdata = cur_read; // [R06]
        end
        if (hit && (req.op == skip_if_bit_set_op)) begin
            next_resp.skip = |(cur_read & bit_mask); // [R02]
        end
        if (hit && (req.op == skip_if_bit_clear_op)) begin
            next_resp.skip = ~|(cur_read & bit_mask); // [R02]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regs         <= '0; // [R11]
            resp         <= '0;
            force_strobe <= 2'b00;
        end else begin
            regs         <= next_regs;
            resp         <= next_resp;
            force_strobe <= next_force;
        end
    end

    assign image = regs;

    AST_BIT_RANGE: assert property (@(posedge clk) disable iff (!reset_n) // [R01]
        (is_bitop && req.addr >= BIT_LIMIT && events == '0) |=> !resp.hit && regs == $past(regs))
        else $error("bit operation above the low range took effect");

    AST_SKIP_VALUE: assert property (@(posedge clk) disable iff (!reset_n) // [R02]
        (hit && req.op == skip_if_bit_set_op) |=> resp.skip == $past(cur_read[req.bit_sel]))
        else $error("bit test returned the wrong bit");

    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!reset_n) // [R03]
        (req.op == io_write_op && req.addr == 8'h15 && events.timer0 == 8'h00)
        |=> regs[TIMER0_FLAGS] == ($past(regs[TIMER0_FLAGS]) & ~$past(req.wdata)))
        else $error("flag did not clear on a written one");

    AST_BIT_ONLY: assert property (@(posedge clk) disable iff (!reset_n) // [R04]
        (hit && is_bitop && w1c_mask(idx) == 8'h00)
        |=> ((regs[$past(idx)] ^ $past(regs[idx])) & ~$past(bit_mask)) == 8'h00)
        else $error("bit operation disturbed other bits");

    AST_IO_READ: assert property (@(posedge clk) disable iff (!reset_n) // [R05]
        (req.op == io_read_op) |=> resp.hit && resp.rdata == $past(cur_read))
        else $error("port read did not return the addressed register");

    AST_DATA_VIEW: assert property (@(posedge clk) disable iff (!reset_n) // [R06]
        (req.op == load_op && req.addr >= 8'h20 && req.addr <= 8'h5f)
        |=> resp.rdata == $past(read_value(req.addr[5:0] - 6'h20, regs, live)))
        else $error("data-space view did not match the short view");

    AST_EXT_ONLY_MEM: assert property (@(posedge clk) disable iff (!reset_n) // [R07]
        is_io |=> !resp.ext ##0 resp.valid)
        else $error("port instruction reached the extended region");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
        (req.op == io_read_op && impl_mask(req.addr[5:0]) == 8'h00) |=> resp.rdata == 8'h00)
        else $error("reserved location read nonzero");

    AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
        (req.op == op_idle) |=> !resp.valid)
        else $error("answer without a request");
endmodule

// ==== io_space_pkg.sv ====
// shared types, offsets and bit masks of the lower register space
// How it works
// (R01) single-bit set and clear reach only short addresses 0x00 to 0x1f
// (R02) bit test returns one chosen bit of a low register for conditional skip
// (R03) event flags clear when written with one, writing zero keeps them
// (R04) single-bit operations change only the named bit, flags included
// (R05) port instructions use short addresses 0x00 to 0x3f, sixty-four locations
// (R06) data-space address equals short address plus 0x20, same register
// (R07) extended region 0x60 to 0xff answers only data-space loads and stores
// (R08) software writes zero into reserved bit positions; the bench writes 0xff to 0x16, whose bits 3, 4, 6 and 7 are reserved
// (R09) software never writes reserved locations such as 0x0c to 0x14
// (R10) reserved locations and bits read zero, writes to them do nothing
// (R11) accesses finish in one cycle, writes taken at the ending edge, reset clears
package io_space_pkg;
    localparam int          SHORT_DEPTH   = 64;
    localparam logic [7:0]  BIT_LIMIT     = 8'h20;
    localparam logic [7:0]  DATA_OFFSET   = 8'h20;
    localparam logic [7:0]  DATA_TOP      = 8'h5f;
    localparam logic [7:0]  EXT_BASE      = 8'h60;
    localparam logic [7:0]  RESET_VALUE   = 8'h00;
    localparam logic [5:0]  PORT_B_PINS   = 6'h03;
    localparam logic [5:0]  PORT_C_PINS   = 6'h06;
    localparam logic [5:0]  PORT_D_PINS   = 6'h09;
    localparam logic [5:0]  TIMER0_FLAGS  = 6'h15;
    localparam logic [5:0]  TIMER1_FLAGS  = 6'h16;
    localparam logic [5:0]  TIMER2_FLAGS  = 6'h17;
    localparam logic [5:0]  PCHG_FLAGS    = 6'h1b;
    localparam logic [5:0]  EXT_IRQ_FLAGS = 6'h1c;
    localparam logic [5:0]  TIMER0_CTL_B  = 6'h25;
    localparam logic [5:0]  SERIAL_STATUS = 6'h2d;
    localparam logic [7:0]  FORCE_BITS    = 8'hc0;
    localparam logic [7:0]  SERIAL_RO     = 8'hc0;

    typedef enum logic [3:0] {
        op_idle, io_read_op, io_write_op, set_bit_io_op, clear_bit_io_op,
        skip_if_bit_set_op, skip_if_bit_clear_op, load_op, memory_write_op
    } op_type;

    typedef struct packed {
        op_type      op;
        logic [7:0]  addr;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } req_type;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        ext;
        logic        skip;
        logic [7:0]  rdata;
    } resp_type;

    typedef struct packed {
        logic [7:0]  timer0;
        logic [7:0]  timer1;
        logic [7:0]  timer2;
        logic [7:0]  pin_change;
        logic [7:0]  external;
    } events_type;

    typedef struct packed {
        logic [7:0]  port_b;
        logic [7:0]  port_c;
        logic [7:0]  port_d;
        logic [7:0]  serial;
    } inputs_type;

    // implemented bits; everything else is reserved and reads zero
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        unique case (a)
            6'h03, 6'h04, 6'h05, 6'h09, 6'h0a, 6'h0b: impl_mask = 8'hff;
            6'h06, 6'h07, 6'h08:                      impl_mask = 8'h7f;
            6'h15, 6'h17, 6'h1b:                      impl_mask = 8'h07;
            6'h16:                                    impl_mask = 8'h27;
            6'h1c, 6'h1d:                             impl_mask = 8'h03;
            6'h1e, 6'h20, 6'h21, 6'h22:               impl_mask = 8'hff;
            6'h1f:                                    impl_mask = 8'h3f;
            6'h23:                                    impl_mask = 8'h83;
            6'h24:                                    impl_mask = 8'hf3;
            6'h25:                                    impl_mask = 8'hcf;
            6'h26, 6'h27, 6'h28, 6'h2a, 6'h2b, 6'h2c: impl_mask = 8'hff;
            6'h2d:                                    impl_mask = 8'hc1;
            default:                                  impl_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        unique case (a)
            TIMER0_FLAGS, TIMER2_FLAGS, PCHG_FLAGS: w1c_mask = 8'h07;
            TIMER1_FLAGS:                           w1c_mask = 8'h27;
            EXT_IRQ_FLAGS:                          w1c_mask = 8'h03;
            default:                                w1c_mask = 8'h00;
        endcase
    endfunction

    // bits that software may not store: pin inputs, peripheral status, strobes
    function automatic logic [7:0] fixed_mask(input logic [5:0] a);
        unique case (a)
            PORT_B_PINS, PORT_D_PINS: fixed_mask = 8'hff;
            PORT_C_PINS:              fixed_mask = 8'h7f;
            TIMER0_CTL_B:             fixed_mask = FORCE_BITS;
            SERIAL_STATUS:            fixed_mask = SERIAL_RO;
            default:                  fixed_mask = 8'h00;
        endcase
    endfunction
endpackage

// ==== core_model.sv ====
// processor core model issuing accesses to the register space
`timescale 1ns/1ps
module core_model (
    // clock
    input  wire logic               clk,
    // request and answer
    output      io_space_pkg::req_type  req,
    input  wire io_space_pkg::resp_type resp
);
    import io_space_pkg::*;
    initial req = '0;
    function automatic logic reserved_loc(input logic [5:0] a);
        return a inside {[6'h00:6'h02], [6'h0c:6'h14], [6'h18:6'h1a], 6'h29};
    endfunction
    // request goes up at a falling edge and drops before a second edge could repeat it
    task automatic access(input op_type op, input logic [7:0] a, input logic [2:0] b,
                          input logic [7:0] d, output resp_type r);
        logic [7:0] s;
        s = (op == memory_write_op) ? a - 8'h20 : a;
        r = '0;
        if ((op inside {io_write_op, memory_write_op}) && a < 8'h60 && reserved_loc(s[5:0]))
            return;
        @(negedge clk);
        req = '{op: op, addr: a, bit_sel: b, wdata: d};
        @(posedge clk);
        #1 r = resp;
        @(negedge clk);
        req = '0;
        if (r.valid !== 1'b1) begin
            @(posedge clk);
            #1 r = resp;
        end
    endtask
endmodule

// ==== tb_io_register_space_decoder.sv ====
// self-checking bench for the lower register space decoder
`timescale 1ns/1ps
module tb_io_register_space_decoder;
    import io_space_pkg::*;
    logic             clk         = 1'b0;
    logic             reset_n     = 1'b0;
    req_type          req;
    resp_type         resp;
    events_type       events      = '0;
    inputs_type       live        = '{8'h5a, 8'h33, 8'hc3, 8'h00};
    logic [63:0][7:0] image;
    logic [1:0]       force_strobe;
    resp_type         r;
    int               mismatches  = 0;
    int               check_count = 0;
    int               cycles      = 0;
    logic [7:0]       rst_list[4] = '{8'h04, 8'h1e, 8'h2a, 8'h2c};
    logic [7:0]       rsv_list[4] = '{8'h00, 8'h0c, 8'h14, 8'h29};

    always #4 clk = ~clk;

    io_register_space_decoder dut (.clk(clk), .reset_n(reset_n), .req(req), .resp(resp),
        .events(events), .live(live), .image(image), .force_strobe(force_strobe));
    core_model core (.clk(clk), .req(req), .resp(resp));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic op(input op_type o, input logic [7:0] a, input logic [2:0] b = 3'h0,
                      input logic [7:0] d = 8'h00);
        core.access(o, a, b, d, r);
    endtask
    task automatic rd(input op_type o, input logic [7:0] a, input logic [7:0] exp);
        core.access(o, a, 3'h0, 8'h00, r);
        check(r.rdata, exp);
    endtask

    // a hang shows up as a run far beyond the hundred or so cycles of the tests
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        for (int i = 0; i < 4; i++) rd(io_read_op, rst_list[i], 8'h00);
        rd(io_read_op, 8'h03, 8'h5a);
        op(io_write_op, 8'h04, 3'h0, 8'ha5);
        rd(io_read_op, 8'h04, 8'ha5);
        check(image[4], 8'ha5);
        rd(load_op, 8'h24, 8'ha5);
        op(memory_write_op, 8'h4b, 3'h0, 8'h3c);
        rd(io_read_op, 8'h2b, 8'h3c);
        rd(io_read_op, 8'h6b, 8'h3c);
        $display("test access views done");
        op(io_write_op, 8'h1e, 3'h0, 8'h81);
        op(set_bit_io_op, 8'h1e, 3'h2);
        rd(io_read_op, 8'h1e, 8'h85);
        op(clear_bit_io_op, 8'h1e, 3'h7);
        rd(io_read_op, 8'h1e, 8'h05);
        op(skip_if_bit_set_op, 8'h1e, 3'h2);
        check({7'h00, r.skip}, 8'h01);
        op(skip_if_bit_clear_op, 8'h1e, 3'h2);
        check({7'h00, r.skip}, 8'h00);
        op(skip_if_bit_clear_op, 8'h1e, 3'h1);
        check({7'h00, r.skip}, 8'h01);
        op(io_write_op, 8'h2a, 3'h0, 8'h0f);
        op(set_bit_io_op, 8'h2a, 3'h7);
        check({7'h00, r.hit}, 8'h00);
        rd(io_read_op, 8'h2a, 8'h0f);
        op(io_write_op, 8'h25, 3'h0, 8'hcf);
        check({6'h00, force_strobe}, 8'h03);
        rd(io_read_op, 8'h25, 8'h0f);
        check({6'h00, force_strobe}, 8'h00);
        $display("test bit access done");
        @(negedge clk);
        events.timer0 = 8'h07;
        events.external = 8'h03;
        events.timer1 = 8'hff;
        @(negedge clk);
        events = '0;
        rd(io_read_op, 8'h15, 8'h07);
        rd(io_read_op, 8'h16, 8'h27);
        op(io_write_op, 8'h16, 3'h0, 8'hff);
        rd(io_read_op, 8'h16, 8'h00);
        op(io_write_op, 8'h15, 3'h0, 8'h00);
        rd(io_read_op, 8'h15, 8'h07);
        op(io_write_op, 8'h15, 3'h0, 8'h01);
        rd(load_op, 8'h35, 8'h06);
        op(set_bit_io_op, 8'h15, 3'h1);
        rd(io_read_op, 8'h15, 8'h04);
        op(clear_bit_io_op, 8'h1c, 3'h0);
        rd(io_read_op, 8'h1c, 8'h03);
        $display("test event flags done");
        for (int i = 0; i < 4; i++) rd(io_read_op, rsv_list[i], 8'h00);
        op(io_write_op, 8'h08, 3'h0, 8'h7f);
        rd(io_read_op, 8'h08, 8'h7f);
        op(memory_write_op, 8'h80, 3'h0, 8'h55);
        rd(load_op, 8'h80, 8'h00);
        check({7'h00, r.ext}, 8'h01);
        op(io_read_op, 8'h80);
        check({7'h00, r.ext}, 8'h00);
        op(load_op, 8'h10);
        check({7'h00, r.hit}, 8'h00);
        $display("test reserved and extended done");
        test_done();
    end
endmodule
